// [src/hyg_target.sv]
// Summary of operation
// - answer only at address 0x40
// - direction bit: high read, low write
// - first written byte is register pointer
// - configuration at 0x02, reserved bits zero
// - reset bit resets, then reads zero
// - bit 13 drives heater enable
// - mode 0: convert only selected quantity
// - mode 1: temperature then humidity
// - bit 11 shows low supply, read only
// - resolution fields for temperature, humidity
// - reset clears reset, heater, resolution fields
// - temperature at 0x00, humidity at 0x01
// - results 16 bit, data MSB aligned
// - result bits 1:0 always zero
// - humidity conversion 2.50/3.85/6.50 ms
// - temperature conversion 3.65/6.35 ms
// - host clock 10 to 400 kHz
// - pointer write to result starts measurement
// - such write mid-conversion restarts it
// - read while converting is not acknowledged
// - read advances pointer, MSB first
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "hyg_defs.svh"
module hyg_target
    import hyg_pkg::*;
#(
    parameter int unsigned HUM8_CYC = `HYG_T_HUM8_NS / `HYG_CLK_NS,
    parameter int unsigned HUM11_CYC = `HYG_T_HUM11_NS / `HYG_CLK_NS,
    parameter int unsigned HUM14_CYC = `HYG_T_HUM14_NS / `HYG_CLK_NS,
    parameter int unsigned TEMP11_CYC = `HYG_T_TEMP11_NS / `HYG_CLK_NS,
    parameter int unsigned TEMP14_CYC = `HYG_T_TEMP14_NS / `HYG_CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    hyg_if.dev link,
    input wire logic [13:0] temp_sample_i,
    input wire logic [13:0] hum_sample_i,
    input wire logic supply_low_i,
    output logic heater_enable_o,
    output logic conv_busy_o
);
    localparam int CW = `HYG_CONV_W;

    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic [1:0] lowv_s_q;
    hyg_dev_st_t st_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] shreg_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic [7:0] msb_q;
    logic rd_q;
    logic half_q;
    logic drv_q;
    logic conv_go_q;
    logic cfg_wr_q;
    logic [15:0] cfg_wdata_q;
    logic heater_enable_q;
    logic mode_q;
    logic temperature_resolution_sel_q;
    logic [1:0] humidity_resolution_sel_q;
    hyg_conv_t cv_q;
    logic seq_q;
    logic [CW-1:0] cnt_q;
    logic [15:0] temp_res_q;
    logic [15:0] hum_res_q;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic busy;
    logic soft_rst;
    logic [7:0] nxt_ptr;
    logic [15:0] cur_val;
    logic [15:0] nxt_val;
    logic [15:0] cfg_val;

    // first stage feeds only the second; stages 1 and 2 feed edge logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            lowv_s_q <= 2'h0;
        end else if (ce_i) begin
            scl_s_q <= {scl_s_q[1:0], link.scl};
            sda_s_q <= {sda_s_q[1:0], link.sda};
            lowv_s_q <= {lowv_s_q[0], supply_low_i};
        end
    end

    assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
    assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    assign busy = (cv_q != CV_IDLE);
    assign soft_rst = cfg_wr_q & cfg_wdata_q[`HYG_CFG_RST];

    assign cfg_val = {1'b0, 1'b0, heater_enable_q, mode_q, lowv_s_q[1],
                      temperature_resolution_sel_q,
                      humidity_resolution_sel_q, `HYG_CFG_RSV_LO};

    function automatic logic [15:0] reg_val(input logic [7:0] p);
        if (p == `HYG_PTR_TEMP) begin
            reg_val = temp_res_q;
        end else if (p == `HYG_PTR_HUM) begin
            reg_val = hum_res_q;
        end else if (p == `HYG_PTR_CFG) begin
            reg_val = cfg_val;
        end else begin
            reg_val = 16'h0000;
        end
    endfunction

    assign nxt_ptr = (ptr_q >= `HYG_PTR_CFG) ? `HYG_PTR_TEMP : ptr_q + 8'h01;
    assign cur_val = reg_val(ptr_q);
    assign nxt_val = reg_val(nxt_ptr);

    // open drain: only ever pulls low
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = ~drv_q;
    assign heater_enable_o = heater_enable_q;
    assign conv_busy_o = busy;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= DS_IDLE;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= `HYG_PTR_TEMP;
            msb_q <= 8'h00;
            rd_q <= 1'b0;
            half_q <= 1'b0;
            drv_q <= 1'b0;
            conv_go_q <= 1'b0;
            cfg_wr_q <= 1'b0;
            cfg_wdata_q <= 16'h0000;
        end else if (ce_i) begin
            conv_go_q <= 1'b0;
            cfg_wr_q <= 1'b0;
            if (start_det) begin
                st_q <= DS_ADDR;
                bit_q <= 4'h0;
                byte_q <= 2'h0;
                drv_q <= 1'b0;
            end else if (stop_det) begin
                st_q <= DS_IDLE;
                drv_q <= 1'b0;
            end else if (st_q != DS_IDLE && scl_rise) begin
                if (bit_q < 4'h8) begin
                    shreg_q <= {shreg_q[6:0], sda_s_q[1]};
                end
                // host not-acknowledge ends the read burst
                if (bit_q == 4'h8 && st_q == DS_READ && sda_s_q[1]) begin
                    st_q <= DS_IDLE;
                end
                bit_q <= bit_q + 4'h1;
            end else if (st_q != DS_IDLE && scl_fall) begin
                if (bit_q == 4'h8) begin
                    if (st_q == DS_ADDR) begin
                        if (shreg_q[7:1] == `HYG_DEV_ADDR &&
                            !(shreg_q[0] && busy)) begin
                            drv_q <= 1'b1;
                            rd_q <= shreg_q[0];
                        end else begin
                            st_q <= DS_IDLE;
                        end
                    end else if (st_q == DS_WRITE) begin
                        drv_q <= 1'b1;
                        if (byte_q != 2'h3) begin
                            byte_q <= byte_q + 2'h1;
                        end
                        if (byte_q == 2'h0) begin
                            ptr_q <= shreg_q;
                            conv_go_q <= (shreg_q == `HYG_PTR_TEMP) ||
                                         (shreg_q == `HYG_PTR_HUM);
                        end else if (byte_q == 2'h1) begin
                            msb_q <= shreg_q;
                        end else if (byte_q == 2'h2 &&
                                     ptr_q == `HYG_PTR_CFG) begin
                            cfg_wr_q <= 1'b1;
                            cfg_wdata_q <= {msb_q, shreg_q};
                        end
                    end else begin
                        drv_q <= 1'b0;
                    end
                end else if (bit_q == 4'h9) begin
                    bit_q <= 4'h0;
                    if (st_q == DS_ADDR && rd_q) begin
                        st_q <= DS_READ;
                        half_q <= 1'b0;
                        tx_q <= cur_val[15:8];
                        drv_q <= ~cur_val[15];
                    end else if (st_q == DS_ADDR) begin
                        st_q <= DS_WRITE;
                        drv_q <= 1'b0;
                    end else if (st_q == DS_READ && !half_q) begin
                        half_q <= 1'b1;
                        tx_q <= cur_val[7:0];
                        drv_q <= ~cur_val[7];
                    end else if (st_q == DS_READ) begin
                        // next register after its low byte
                        half_q <= 1'b0;
                        ptr_q <= nxt_ptr;
                        tx_q <= nxt_val[15:8];
                        drv_q <= ~nxt_val[15];
                    end else begin
                        drv_q <= 1'b0;
                    end
                end else if (st_q == DS_READ && bit_q != 4'h0) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    drv_q <= ~tx_q[6];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            heater_enable_q <= 1'b0;
            mode_q <= 1'b0;
            temperature_resolution_sel_q <= `HYG_RES_RST;
            humidity_resolution_sel_q <= `HYG_HUMIDITY_RESOLUTION_SEL_RST;
        end else if (ce_i && soft_rst) begin
            heater_enable_q <= 1'b0;
            temperature_resolution_sel_q <= `HYG_RES_RST;
            humidity_resolution_sel_q <= `HYG_HUMIDITY_RESOLUTION_SEL_RST;
        end else if (ce_i && cfg_wr_q) begin
            heater_enable_q <= cfg_wdata_q[`HYG_CFG_HEATER_ENABLE];
            mode_q <= cfg_wdata_q[`HYG_CFG_MODE];
            temperature_resolution_sel_q <= cfg_wdata_q[`HYG_CFG_TEMPERATURE_RESOLUTION_SEL];
            humidity_resolution_sel_q <=
                cfg_wdata_q[`HYG_CFG_HUMIDITY_RESOLUTION_SEL_HI:`HYG_CFG_HUMIDITY_RESOLUTION_SEL_LO];
        end
    end

    function automatic logic [CW-1:0] conv_len(input logic hum);
        int unsigned c;
        if (!hum) begin
            c = temperature_resolution_sel_q ? TEMP11_CYC : TEMP14_CYC;
        end else if (humidity_resolution_sel_q == `HYG_HUMIDITY_RESOLUTION_SEL_11) begin
            c = HUM11_CYC;
        end else if (humidity_resolution_sel_q == `HYG_HUMIDITY_RESOLUTION_SEL_8) begin
            c = HUM8_CYC;
        end else begin
            c = HUM14_CYC;
        end
        conv_len = CW'(c - 1);
    endfunction

    // MSB aligned, low bits zero at lower resolution
    function automatic logic [15:0] quant(input logic [13:0] s,
                                          input logic [1:0] res);
        if (res == `HYG_HUMIDITY_RESOLUTION_SEL_11) begin
            quant = {s[13:3], 5'h00};
        end else if (res == `HYG_HUMIDITY_RESOLUTION_SEL_8) begin
            quant = {s[13:6], 8'h00};
        end else begin
            quant = {s, 2'h0};
        end
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cv_q <= CV_IDLE;
            seq_q <= 1'b0;
            cnt_q <= '0;
            temp_res_q <= 16'h0000;
            hum_res_q <= 16'h0000;
        end else if (ce_i) begin
            if (soft_rst) begin
                cv_q <= CV_IDLE;
            end else if (conv_go_q) begin
                // a new trigger restarts any conversion
                seq_q <= mode_q;
                if (mode_q || ptr_q == `HYG_PTR_TEMP) begin
                    cv_q <= CV_TEMP;
                    cnt_q <= conv_len(1'b0);
                end else begin
                    cv_q <= CV_HUM;
                    cnt_q <= conv_len(1'b1);
                end
            end else if (cv_q != CV_IDLE && cnt_q != '0) begin
                cnt_q <= cnt_q - CW'(1);
            end else if (cv_q == CV_TEMP) begin
                temp_res_q <= quant(temp_sample_i,
                                    {1'b0, temperature_resolution_sel_q});
                if (seq_q) begin
                    cv_q <= CV_HUM;
                    cnt_q <= conv_len(1'b1);
                end else begin
                    cv_q <= CV_IDLE;
                end
            end else if (cv_q == CV_HUM) begin
                hum_res_q <= quant(hum_sample_i, humidity_resolution_sel_q);
                cv_q <= CV_IDLE;
            end
        end
    end
endmodule

// [common/hyg_defs.svh]
`ifndef HYG_DEFS_SVH
`define HYG_DEFS_SVH

// serial link
`define HYG_DEV_ADDR 7'h40
`define HYG_PTR_TEMP 8'h00
`define HYG_PTR_HUM 8'h01
`define HYG_PTR_CFG 8'h02

// measurement_configuration field positions
`define HYG_CFG_RST 15
`define HYG_CFG_HEATER_ENABLE 13
`define HYG_CFG_MODE 12
`define HYG_CFG_LOWV 11
`define HYG_CFG_TEMPERATURE_RESOLUTION_SEL 10
`define HYG_CFG_HUMIDITY_RESOLUTION_SEL_HI 9
`define HYG_CFG_HUMIDITY_RESOLUTION_SEL_LO 8
`define HYG_CFG_RSV_LO 8'h00
`define HYG_RES_RST 1'b0
`define HYG_HUMIDITY_RESOLUTION_SEL_RST 2'h0
`define HYG_HUMIDITY_RESOLUTION_SEL_14 2'h0
`define HYG_HUMIDITY_RESOLUTION_SEL_11 2'h1
`define HYG_HUMIDITY_RESOLUTION_SEL_8 2'h2

// timing
`define HYG_CLK_NS 8
`define HYG_T_HUM8_NS 2500000
`define HYG_T_HUM11_NS 3850000
`define HYG_T_HUM14_NS 6500000
`define HYG_T_TEMP11_NS 3650000
`define HYG_T_TEMP14_NS 6350000
`define HYG_CONV_W 20

// controller registers (byte offsets)
`define HYG_REG_CTRL 8'h00
`define HYG_REG_STATUS 8'h04
`define HYG_REG_WDATA 8'h08
`define HYG_REG_RDATA 8'h0C
`define HYG_REG_DIV 8'h10
`define HYG_DIV_RST 16'h0138

`endif

// [common/hyg_pkg.sv]
package hyg_pkg;
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_ADDR = 2'b01,
        DS_WRITE = 2'b10,
        DS_READ = 2'b11
    } hyg_dev_st_t;
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_TEMP = 2'b01,
        CV_HUM = 2'b10
    } hyg_conv_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_START = 2'b01,
        HS_BIT = 2'b10,
        HS_STOP = 2'b11
    } hyg_host_st_t;
    typedef enum logic [1:0] {
        OP_PTR = 2'b00,
        OP_REG = 2'b01,
        OP_READ = 2'b10
    } hyg_op_t;
endpackage

// [common/hyg_if.sv]
`timescale 1ns/1ps
interface hyg_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;
    // open-drain wires with pull-ups
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    modport host (output host_scl_o, output host_scl_oe_n,
                  output host_sda_o, output host_sda_oe_n,
                  input scl, input sda);
    modport dev (output dev_sda_o, output dev_sda_oe_n,
                 input scl, input sda);
endinterface

// [src/hyg_host_ctrl.sv]
`timescale 1ns/1ps
`include "hyg_defs.svh"
module hyg_host_ctrl
    import hyg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    hyg_if.host link,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic [31:0] hrdata_q;
    hyg_op_t op_q;
    logic [2:0] len_q;
    logic [7:0] ptr_q;
    logic [15:0] wdata_q;
    logic [15:0] div_q;
    logic [31:0] rdata_q;
    logic nack_q;
    logic [1:0] sda_s_q;
    hyg_host_st_t hs_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [15:0] cnt_q;
    logic scl_low_q;
    logic sda_low_q;

    logic go;
    logic tick;
    logic is_rx;
    logic last;
    logic [2:0] nbytes;
    logic [31:0] rd_mux;

    // zero-wait slave, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    always_comb begin
        if (haddr_i[7:0] == `HYG_REG_CTRL) begin
            rd_mux = {16'h0000, ptr_q, 3'h0, len_q, op_q};
        end else if (haddr_i[7:0] == `HYG_REG_STATUS) begin
            rd_mux = {30'h0, nack_q, hs_q != HS_IDLE};
        end else if (haddr_i[7:0] == `HYG_REG_WDATA) begin
            rd_mux = {16'h0000, wdata_q};
        end else if (haddr_i[7:0] == `HYG_REG_RDATA) begin
            rd_mux = rdata_q;
        end else if (haddr_i[7:0] == `HYG_REG_DIV) begin
            rd_mux = {16'h0000, div_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // commands written while busy are dropped
    assign go = ce_i && dp_wr_q && dp_addr_q == `HYG_REG_CTRL &&
                hs_q == HS_IDLE;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            op_q <= OP_PTR;
            len_q <= 3'h4;
            ptr_q <= 8'h00;
            wdata_q <= 16'h0000;
            div_q <= `HYG_DIV_RST;
        end else if (ce_i) begin
            if (hready_i) begin
                dp_wr_q <= hsel_i && htrans_i[1] && hwrite_i;
                dp_addr_q <= haddr_i[7:0];
                if (hsel_i && htrans_i[1] && !hwrite_i) begin
                    hrdata_q <= rd_mux;
                end
            end
            if (go) begin
                op_q <= hyg_op_t'(hwdata_i[1:0]);
                len_q <= hwdata_i[4:2];
                ptr_q <= hwdata_i[15:8];
            end else if (dp_wr_q && dp_addr_q == `HYG_REG_WDATA) begin
                wdata_q <= hwdata_i[15:0];
            end else if (dp_wr_q && dp_addr_q == `HYG_REG_DIV) begin
                div_q <= hwdata_i[15:0];
            end
        end
    end

    // data bytes after the address byte
    assign nbytes = (op_q == OP_PTR) ? 3'h1 :
                    (op_q == OP_REG) ? 3'h3 : len_q;
    assign is_rx = (op_q == OP_READ) && (idx_q != 3'h0);
    assign last = (idx_q == nbytes);
    assign tick = (hs_q != HS_IDLE) && (cnt_q == 16'h0000);

    function automatic logic [7:0] tx_byte(input logic [2:0] i);
        if (i == 3'h0) begin
            tx_byte = {`HYG_DEV_ADDR, op_q == OP_READ};
        end else if (i == 3'h1) begin
            tx_byte = ptr_q;
        end else if (i == 3'h2) begin
            tx_byte = wdata_q[15:8];
        end else begin
            tx_byte = wdata_q[7:0];
        end
    endfunction

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe_n = ~scl_low_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = ~sda_low_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_s_q <= 2'h3;
            cnt_q <= 16'h0000;
        end else if (ce_i) begin
            sda_s_q <= {sda_s_q[0], link.sda};
            if (hs_q == HS_IDLE || cnt_q == 16'h0000) begin
                cnt_q <= div_q;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // each bit: scl low, set sda, release scl, sample before falling
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_q <= HS_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            nack_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else if (go) begin
            hs_q <= HS_START;
            ph_q <= 2'h0;
            idx_q <= 3'h0;
            bit_q <= 4'h0;
            nack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i && tick) begin
            ph_q <= ph_q + 2'h1;
            if (hs_q == HS_START) begin
                if (ph_q == 2'h0) begin
                    sda_low_q <= 1'b1;
                end else begin
                    scl_low_q <= 1'b1;
                    hs_q <= HS_BIT;
                    ph_q <= 2'h0;
                    tx_q <= tx_byte(3'h0);
                end
            end else if (hs_q == HS_STOP) begin
                if (ph_q == 2'h0) begin
                    sda_low_q <= 1'b1;
                end else if (ph_q == 2'h1) begin
                    scl_low_q <= 1'b0;
                end else if (ph_q == 2'h2) begin
                    sda_low_q <= 1'b0;
                end else begin
                    hs_q <= HS_IDLE;
                end
            end else if (hs_q == HS_BIT) begin
                if (ph_q == 2'h0 && bit_q < 4'h8) begin
                    sda_low_q <= ~is_rx & ~tx_q[7];
                end else if (ph_q == 2'h0) begin
                    // acknowledge every read byte but the last
                    sda_low_q <= is_rx & ~last;
                end else if (ph_q == 2'h1) begin
                    scl_low_q <= 1'b0;
                end else if (ph_q == 2'h3) begin
                    scl_low_q <= 1'b1;
                    if (bit_q < 4'h8) begin
                        rx_q <= {rx_q[6:0], sda_s_q[1]};
                        tx_q <= {tx_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end else begin
                        bit_q <= 4'h0;
                        if (is_rx) begin
                            rdata_q <= {rdata_q[23:0], rx_q};
                        end
                        if (!is_rx && sda_s_q[1]) begin
                            nack_q <= 1'b1;
                            hs_q <= HS_STOP;
                        end else if (last) begin
                            hs_q <= HS_STOP;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            tx_q <= tx_byte(idx_q + 3'h1);
                        end
                    end
                end
            end
        end
    end
endmodule

// [verification/hyg_link_asserts.sv]
`timescale 1ns/1ps
module hyg_link_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic bus_q;
    // frame tracker: set at start, cleared at stop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) bus_q <= 1'b0;
        else if (scl && $fell(sda)) bus_q <= 1'b1;
        else if (scl && $rose(sda)) bus_q <= 1'b0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
    property p_rst; disable iff (1'b0) !rst_n_i
        |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n; endproperty
    property p_hold; scl && $past(scl) |-> $stable(dev_sda_oe_n); endproperty
    property p_start; scl && $fell(sda) |-> !host_sda_oe_n; endproperty
    property p_stop; scl && $rose(sda) |-> !$past(host_sda_oe_n); endproperty
    property p_idle; !bus_q |-> dev_sda_oe_n; endproperty
    property p_drv; $fell(dev_sda_oe_n) |-> !scl; endproperty
    property p_rel; $rose(dev_sda_oe_n) |-> !scl; endproperty
    a_od: assert property (p_od)
        else $error("open-drain line driven high");
    a_rst: assert property (p_rst)
        else $error("line pulled during reset");
    a_hold: assert property (p_hold)
        else $error("target data changed while clock high");
    a_start: assert property (p_start)
        else $error("start not made by host");
    a_stop: assert property (p_stop)
        else $error("stop not made by host");
    a_idle: assert property (p_idle)
        else $error("target drives outside a frame");
    a_drv: assert property (p_drv)
        else $error("target grabbed line while clock high");
    a_rel: assert property (p_rel)
        else $error("target released line while clock high");
    c_start: cover property (scl && $fell(sda));
    c_ack: cover property ($rose(scl) && !dev_sda_oe_n);
    c_stop: cover property (scl && $rose(sda));
endmodule

// [verification/test_humidity_temp_sensor_i2c_target.sv]
`timescale 1ns/1ps
`include "hyg_defs.svh"
module test_humidity_temp_sensor_i2c_target;
    logic clk_i = 0, rst_n_i = 1, hsel_i = 0, hwrite_i = 0, sl = 1, ce = 1;
    logic [1:0] htrans_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, st, q;
    logic hreadyout_o, hresp_o, heater_enable, busy;
    logic [13:0] ts = 14'h2A5C, hs = 14'h1337;
    int mismatches = 0, comparisons = 0;
    hyg_if link ();
    // long enough that a read can land mid-conversion
    hyg_target #(.HUM8_CYC(400), .HUM11_CYC(500), .HUM14_CYC(600),
        .TEMP11_CYC(450), .TEMP14_CYC(800)) hyg_target_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .link(link),
        .temp_sample_i(ts), .hum_sample_i(hs), .supply_low_i(sl),
        .heater_enable_o(heater_enable), .conv_busy_o(busy));
    hyg_host_ctrl hyg_host_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .link(link), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
    hyg_link_asserts hyg_link_asserts_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .host_scl_o(link.host_scl_o),
        .host_scl_oe_n(link.host_scl_oe_n), .host_sda_o(link.host_sda_o),
        .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));
    initial forever #4 clk_i = ~clk_i;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic lim(input int n);
        if (n >= 2000) begin
            mismatches++;
            stop_test;
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 2000);
        lim(n);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        wt;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wt;
        q = hrdata_o;
        chkb("hresp", 1'b0, hresp_o);
    endtask
    // issue a link command, then poll until the controller is idle
    task automatic go(input logic [1:0] op, input [2:0] c, input [7:0] p);
        int n;
        ahb(1, `HYG_REG_CTRL, {16'h0, p, 3'h0, c, op});
        n = 0;
        do begin
            ahb(0, `HYG_REG_STATUS, 0);
            n++;
        end while (q[0] !== 1'b0 && n < 2000);
        lim(n);
        st = q;
    endtask
    task automatic waitc;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        lim(n);
    endtask
    task automatic rd_res(input [2:0] c, input [7:0] p);
        go(2, c, p);
        ahb(0, `HYG_REG_RDATA, 0);
    endtask
    initial begin
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        ahb(0, `HYG_REG_DIV, 0);
        chk("div", {16'h0, `HYG_DIV_RST}, q);
        chkb("heater", 1'b0, heater_enable); // heater off
        ahb(1, `HYG_REG_DIV, 32'h7); // sped up
        $display("test reset done");
        ahb(1, `HYG_REG_WDATA, 32'h2000);
        go(1, 0, `HYG_PTR_CFG); // pointer then data
        chkb("heater", 1'b1, heater_enable); // heater on
        rd_res(2, `HYG_PTR_CFG);
        chk("cfg", 32'h2800, q); // supply flag
        $display("test config done");
        go(0, 0, `HYG_PTR_TEMP);
        chkb("busy", 1'b1, busy); // trigger
        go(2, 1, `HYG_PTR_TEMP);
        chk("nack", 32'h2, st & 32'h2); // busy read
        waitc;
        rd_res(2, `HYG_PTR_TEMP);
        chk("temp", {16'h0, ts, 2'h0}, q); // low bits zero
        chk("nack", 32'h0, st & 32'h2); // result read
        $display("test single done");
        ahb(1, `HYG_REG_WDATA, 32'h3600);
        go(1, 0, `HYG_PTR_CFG);
        go(0, 0, `HYG_PTR_TEMP);
        waitc;
        rd_res(4, `HYG_PTR_TEMP);
        chk("both", {ts, 2'h0, hs, 2'h0} & 32'hFFE0FF00, q);
        $display("test sequence done");
        ahb(1, `HYG_REG_WDATA, 32'hB600);
        go(1, 0, `HYG_PTR_CFG);
        chkb("heater", 1'b0, heater_enable); // soft reset
        rd_res(2, `HYG_PTR_CFG);
        chk("cfg", 32'h1800, q); // fields cleared
        $display("test soft reset done");
        sl <= 1'b0;
        rd_res(2, `HYG_PTR_CFG);
        chk("cfg", 32'h1000, q); // supply good
        ts <= 14'h1C3B;
        go(0, 0, `HYG_PTR_TEMP);
        ce <= 1'b0;
        repeat (1500) @(posedge clk_i);
        chkb("busy", 1'b1, busy); // frozen
        ce <= 1'b1;
        waitc;
        rd_res(4, `HYG_PTR_TEMP);
        chk("both", {ts, 2'h0, hs, 2'h0}, q); // 14 bit
        $display("test freeze done");
        stop_test;
    end
endmodule
